// ---- include/timer_pm_defines.vh ----
// Register offsets, field positions and constants of the capture/compare timer channel.
`ifndef TIMER_PM_DEFINES_VH
`define TIMER_PM_DEFINES_VH
// ***************************************************************
// Register byte addresses
// ***************************************************************
`define OFS_TIMER_COUNT        12'h000
`define OFS_CAPTURE_COMPARE_A  12'h004
`define OFS_CAPTURE_COMPARE_B  12'h008
`define OFS_TIMER_MODE_CONTROL 12'h00C
`define OFS_CC_CONTROL         12'h010
`define OFS_TIMER_OUT_CONTROL  12'h014
`define OFS_PRESCALER_EDGE     12'h018
`define OFS_IRQ_STATUS         12'h01C
`define OFS_IRQ_MASK           12'h020
// ***************************************************************
// Field positions
// ***************************************************************
`define MODE_SEL_HI_BIT        3
`define MODE_SEL_LO_BIT        2
`define OVERFLOW_BIT           0
`define ROLE_A_BIT             0
`define TRIG_A_PHASE_BIT       1
`define ROLE_B_BIT             2
`define ONESHOT_TRIG_BIT       6
`define ONESHOT_EN_BIT         5
`define TOGGLE_B_BIT           4
`define LEVEL_SET_BIT          3
`define LEVEL_CLR_BIT          2
`define TOGGLE_A_BIT           1
`define OUT_EN_BIT             0
`define CLOCK_SEL_LO_BIT       0
`define EDGE_A_LO_BIT          4
`define EDGE_B_LO_BIT          6
// ***************************************************************
// Encodings and reset values
// ***************************************************************
`define MODE_STOP              2'h0
`define MODE_FREE_RUN          2'h1
`define MODE_CLEAR_ON_EDGE     2'h2
`define EDGE_FALL              2'h0
`define EDGE_RISE              2'h1
`define EDGE_BOTH              2'h3
`define IRQ_MATCH_A_BIT        0
`define IRQ_MATCH_B_BIT        1
`define IRQ_OVERFLOW_BIT       2
`define REG8_RESET             8'h00
`define REG16_RESET            16'h0000
`define COUNT_MAX              16'hFFFF
`endif

// ---- hw/edge_detect.v ----
// Programmable edge detector for one timer input pin.
`default_nettype none
module edge_detect (
   input  wire       sys_clk,
   input  wire       rst_b,
   input  wire       pin,
   input  wire [1:0] edge_sel,
   output wire       valid_edge,
   output wire       opposite_edge
);
   reg  pin_q;
   wire rise;
   wire fall;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin;
      end
   end

   assign rise = pin & ~pin_q;
   assign fall = ~pin & pin_q;
   // Setting 10 is prohibited and detects nothing.
   // edge select decode
   assign valid_edge    = (edge_sel == 2'h0) ? fall :
                          (edge_sel == 2'h1) ? rise :
                          (edge_sel == 2'h3) ? (rise | fall) : 1'b0;
   assign opposite_edge = (edge_sel == 2'h0) ? rise :
                          (edge_sel == 2'h1) ? fall : 1'b0;
endmodule // edge_detect
`default_nettype wire

// ---- hw/timer_pulse_measure_oneshot.v ----
// One channel of a 16-bit timer with capture, compare, one-shot and APB registers.
`include "timer_pm_defines.vh"
`default_nettype none
module timer_pulse_measure_oneshot #(
   parameter PRESCALE_W = 4
) (
   input  wire        sys_clk,
   input  wire        rst_b,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        trigger_in_a,
   input  wire        trigger_in_b,
   output wire        timer_out_pin,
   output wire        irq
);
   // ***************************************************************
   // Registers
   // ***************************************************************
   reg  [15:0]           timer_count_q;
   reg  [15:0]           capture_compare_a_q;
   reg  [15:0]           capture_compare_b_q;
   reg  [3:0]            mode_ctl_q;
   reg  [2:0]            cc_ctl_q;
   reg  [6:0]            out_ctl_q;
   reg  [7:0]            prescale_edge_q;
   reg  [2:0]            irq_status_q;
   reg  [2:0]            irq_mask_q;
   reg                   out_level_q;
   reg                   oneshot_active_q;
   reg  [PRESCALE_W-1:0] prescale_cnt_q;

   wire wr_en = psel & penable & pwrite;
   wire [1:0] mode = mode_ctl_q[`MODE_SEL_HI_BIT:`MODE_SEL_LO_BIT];
   wire running = (mode != `MODE_STOP);
   wire role_a_capture = cc_ctl_q[`ROLE_A_BIT];
   wire role_b_capture = cc_ctl_q[`ROLE_B_BIT];
   wire trig_a_phase = cc_ctl_q[`TRIG_A_PHASE_BIT];
   wire oneshot_en = out_ctl_q[`ONESHOT_EN_BIT];
   wire [1:0] clock_sel = prescale_edge_q[`CLOCK_SEL_LO_BIT+1:`CLOCK_SEL_LO_BIT];
   wire [1:0] edge_a_sel = prescale_edge_q[`EDGE_A_LO_BIT+1:`EDGE_A_LO_BIT];
   wire [1:0] edge_b_sel = prescale_edge_q[`EDGE_B_LO_BIT+1:`EDGE_B_LO_BIT];

   // ***************************************************************
   // Edge detection of the two input pins
   // ***************************************************************
   wire a_valid;
   wire a_opposite;
   wire b_valid;

   edge_detect u_edge_a (
      .sys_clk       (sys_clk),
      .rst_b         (rst_b),
      .pin           (trigger_in_a),
      .edge_sel      (edge_a_sel),
      .valid_edge    (a_valid),
      .opposite_edge (a_opposite)
   );

   edge_detect u_edge_b (
      .sys_clk       (sys_clk),
      .rst_b         (rst_b),
      .pin           (trigger_in_b),
      .edge_sel      (edge_b_sel),
      .valid_edge    (b_valid),
      .opposite_edge ()
   );

   // ***************************************************************
   // Count clock: 1, 4, 2^PRESCALE_W or 2^PRESCALE_W system clocks per tick for clock_sel 0, 1, 2, 3
   // ***************************************************************
   // Setting 11 counts the same internal clock as setting 10; software keeps to internal clocks.
   // internal count source
   wire [PRESCALE_W-1:0] prescale_top =
      (clock_sel == 2'h0) ? {PRESCALE_W{1'b0}} :
      (clock_sel == 2'h1) ? {{(PRESCALE_W-2){1'b0}}, 2'h3} :
      {PRESCALE_W{1'b1}};
   wire count_tick = running & (prescale_cnt_q == prescale_top);

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescale_cnt_q <= {PRESCALE_W{1'b0}};
      end else if (!running || count_tick) begin
         prescale_cnt_q <= {PRESCALE_W{1'b0}};
      end else begin
         prescale_cnt_q <= prescale_cnt_q + 1'b1;
      end
   end

   // ***************************************************************
   // Capture triggers and compare matches
   // ***************************************************************
   // two-input capture routing
   wire cap_a_trig = trig_a_phase ? a_opposite : b_valid;
   wire cap_a = running & role_a_capture & cap_a_trig;
   wire cap_b = running & role_b_capture & a_valid;
   wire oneshot_go = wr_en & (paddr == `OFS_TIMER_OUT_CONTROL)
                     & pwdata[`ONESHOT_TRIG_BIT] & oneshot_en & running;
   wire edge_clear = (mode == `MODE_CLEAR_ON_EDGE) & a_valid;
   wire match_a = count_tick & ~role_a_capture & (timer_count_q == capture_compare_a_q);
   wire match_b = count_tick & ~role_b_capture & (timer_count_q == capture_compare_b_q);
   wire wrap = count_tick & ~edge_clear & (timer_count_q == `COUNT_MAX);

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_count_q <= `REG16_RESET;
      end else if (!running) begin
         timer_count_q <= `REG16_RESET;
      end else if (edge_clear || oneshot_go) begin
         timer_count_q <= `REG16_RESET;
      end else if (count_tick) begin
         timer_count_q <= timer_count_q + 16'h0001;
      end
   end

   // Compare registers must stay unchanged while running; hardware does not lock them.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         capture_compare_a_q <= `REG16_RESET;
         capture_compare_b_q <= `REG16_RESET;
      end else begin
         if (cap_a) begin
            capture_compare_a_q <= timer_count_q;
         end else if (wr_en && paddr == `OFS_CAPTURE_COMPARE_A) begin
            capture_compare_a_q <= pwdata[15:0];
         end
         if (cap_b) begin
            capture_compare_b_q <= timer_count_q;
         end else if (wr_en && paddr == `OFS_CAPTURE_COMPARE_B) begin
            capture_compare_b_q <= pwdata[15:0];
         end
      end
   end

   // ***************************************************************
   // Timer output
   // ***************************************************************
   wire toggle_a = match_a & out_ctl_q[`TOGGLE_A_BIT];
   wire toggle_b = match_b & out_ctl_q[`TOGGLE_B_BIT];
   // In one-shot mode toggling happens only while the single pulse is armed.
   wire allow_toggle = ~oneshot_en | oneshot_active_q;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_level_q      <= 1'b0;
         oneshot_active_q <= 1'b0;
      end else begin
         if (oneshot_go) begin
            oneshot_active_q <= 1'b1;
         end else if (match_b || !running || !oneshot_en) begin
            oneshot_active_q <= 1'b0;
         end
         if (!running && wr_en && paddr == `OFS_TIMER_OUT_CONTROL
             && pwdata[`LEVEL_SET_BIT] && !pwdata[`LEVEL_CLR_BIT]) begin
            out_level_q <= 1'b1;
         end else if (!running && wr_en && paddr == `OFS_TIMER_OUT_CONTROL
             && !pwdata[`LEVEL_SET_BIT] && pwdata[`LEVEL_CLR_BIT]) begin
            out_level_q <= 1'b0;
         end else if (allow_toggle && (toggle_a ^ toggle_b)) begin
            out_level_q <= ~out_level_q;
         end
      end
   end

   assign timer_out_pin = out_level_q & out_ctl_q[`OUT_EN_BIT];

   // ***************************************************************
   // Control registers, overflow flag and interrupts
   // ***************************************************************
   wire [2:0] irq_events = {wrap, match_b | cap_b, match_a | cap_a};
   wire       wr_mode    = wr_en && paddr == `OFS_TIMER_MODE_CONTROL;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ctl_q      <= 4'h0;
         cc_ctl_q        <= 3'h0;
         out_ctl_q       <= 7'h00;
         prescale_edge_q <= `REG8_RESET;
         irq_status_q    <= 3'h0;
         irq_mask_q      <= 3'h7;
      end else begin
         if (wr_mode) begin
            mode_ctl_q[3:1] <= pwdata[3:1];
         end
         // sticky overflow, set wins over clear
         if (wrap) begin
            mode_ctl_q[`OVERFLOW_BIT] <= 1'b1;
         end else if (wr_mode && !pwdata[`OVERFLOW_BIT]) begin
            mode_ctl_q[`OVERFLOW_BIT] <= 1'b0;
         end
         if (wr_en && paddr == `OFS_CC_CONTROL) begin
            cc_ctl_q <= pwdata[2:0];
         end
         // Trigger and level bits are strobes; they never stay stored.
         if (wr_en && paddr == `OFS_TIMER_OUT_CONTROL) begin
            out_ctl_q <= {1'b0, pwdata[5:4], 2'h0, pwdata[1:0]};
         end
         if (wr_en && paddr == `OFS_PRESCALER_EDGE) begin
            prescale_edge_q <= pwdata[7:0];
         end
         if (wr_en && paddr == `OFS_IRQ_MASK) begin
            irq_mask_q <= pwdata[2:0];
         end
         if (wr_en && paddr == `OFS_IRQ_STATUS) begin
            irq_status_q <= (irq_status_q & ~pwdata[2:0]) | irq_events;
         end else begin
            irq_status_q <= irq_status_q | irq_events;
         end
      end
   end

   assign irq = |(irq_status_q & ~irq_mask_q);

   // ***************************************************************
   // APB read path
   // ***************************************************************
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always @* begin
      case (paddr)
         `OFS_TIMER_COUNT:        prdata = {16'h0000, timer_count_q};
         `OFS_CAPTURE_COMPARE_A:  prdata = {16'h0000, capture_compare_a_q};
         `OFS_CAPTURE_COMPARE_B:  prdata = {16'h0000, capture_compare_b_q};
         `OFS_TIMER_MODE_CONTROL: prdata = {28'h0000000, mode_ctl_q};
         `OFS_CC_CONTROL:         prdata = {29'h0, cc_ctl_q};
         `OFS_TIMER_OUT_CONTROL:  prdata = {25'h0, out_ctl_q};
         `OFS_PRESCALER_EDGE:     prdata = {24'h000000, prescale_edge_q};
         `OFS_IRQ_STATUS:         prdata = {29'h0, irq_status_q};
         `OFS_IRQ_MASK:           prdata = {29'h0, irq_mask_q};
         default:                 prdata = 32'h00000000;
      endcase
   end
endmodule // timer_pulse_measure_oneshot
`default_nettype wire

// ---- tb/pulse_source.sv ----
// External pulse source that drives the two timer input pins.
`default_nettype none
module pulse_source (
   input  wire logic sys_clk,
   output var  logic pin_a,
   output var  logic pin_b
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // both pins toggle
   // Pin b rises lag cycles after pin a, and both pins fall in the same cycle.
   task automatic pulse(input int hi, input int lag, input int lo);
      @(posedge sys_clk);
      pin_a <= 1'b1;
      repeat (lag) @(posedge sys_clk);
      pin_b <= 1'b1;
      repeat (hi) @(posedge sys_clk);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (lo) @(posedge sys_clk);
   endtask
endmodule // pulse_source
`default_nettype wire

// ---- tb/timer_pulse_measure_oneshot_assertions.sv ----
// Concurrent checks on the ports of the capture/compare timer channel.
`default_nettype none
`include "timer_pm_defines.vh"
module timer_pm_checker #(
   parameter PRESCALE_W = 4
) (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        trigger_in_a,
   input wire logic        trigger_in_b,
   input wire logic        timer_out_pin,
   input wire logic        irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic       rd_cnt, rd_mode, rd_stat, oe_q;
   logic [1:0] mode_q;
   logic [2:0] mask_q;
   assign rd_cnt  = psel && !pwrite && paddr == `OFS_TIMER_COUNT;
   assign rd_mode = psel && !pwrite && paddr == `OFS_TIMER_MODE_CONTROL;
   assign rd_stat = psel && !pwrite && paddr == `OFS_IRQ_STATUS;
   // Shadows of software writes, so the checks know mask, mode and enable.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= 3'h7;
         mode_q <= 2'h0;
         oe_q   <= 1'b0;
      end else if (psel && penable && pwrite && pready) begin
         if (paddr == `OFS_IRQ_MASK) mask_q <= pwdata[2:0];
         if (paddr == `OFS_TIMER_MODE_CONTROL) mode_q <= pwdata[3:2];
         if (paddr == `OFS_TIMER_OUT_CONTROL) oe_q <= pwdata[`OUT_EN_BIT];
      end
   end
   bus_ready_a: assert property (pready && !pslverr)
      else $error("bus answer not ready");
   count_upper_a: assert property (rd_cnt |-> prdata[31:16] == 16'h0000)
      else $error("count upper bits set");
   count_step_a: assert property (rd_cnt && $past(rd_cnt) |-> prdata[15:0] == 16'h0000
      || prdata[15:0] - $past(prdata[15:0]) <= 16'h0001) else $error("count jumped");
   count_stop_a: assert property (rd_cnt && mode_q == 2'h0 && $past(mode_q) == 2'h0
      |-> prdata[15:0] == 16'h0000) else $error("stopped count not zero");
   ovf_sticky_a: assert property (rd_mode && $past(rd_mode && prdata[0]) |-> prdata[0])
      else $error("overflow flag lost");
   irq_level_a: assert property (rd_stat |-> irq == |(prdata[2:0] & ~mask_q))
      else $error("irq level wrong");
   out_gate_a: assert property (!oe_q && !$past(oe_q) |-> !timer_out_pin)
      else $error("output driven while disabled");
   trig_zero_a: assert property (psel && paddr == `OFS_TIMER_OUT_CONTROL
      |-> !prdata[`ONESHOT_TRIG_BIT]) else $error("trigger reads one");
endmodule // timer_pm_checker
bind timer_pulse_measure_oneshot timer_pm_checker #(.PRESCALE_W(PRESCALE_W)) checker_inst (
   .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .trigger_in_a(trigger_in_a), .trigger_in_b(trigger_in_b),
   .timer_out_pin(timer_out_pin), .irq(irq));
`default_nettype wire

// ---- tb/tb_timer_pulse_measure_oneshot.sv ----
// Self-checking bench for the capture/compare timer channel.
`default_nettype none
`include "timer_pm_defines.vh"
module tb_timer_pulse_measure_oneshot;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic        pin_a, pin_b, timer_out_pin, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, ev, mv;
   logic [15:0] va, vb, df;
   int          n_mismatch, n_checks, cyc, hi_n;
   logic [31:0] exp_q[$], msk_q[$];
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   timer_pulse_measure_oneshot timer_pulse_measure_oneshot_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_in_a(pin_a), .trigger_in_b(pin_b), .timer_out_pin(timer_out_pin), .irq(irq));
   pulse_source pulse_source_inst (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One transfer with an idle cycle after it; a zero mask means the read is not checked.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e = 0, input logic [31:0] m = 0);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic cfg(input logic [7:0] md, input logic [7:0] cc, input logic [7:0] pr);
      apb(1, `OFS_TIMER_MODE_CONTROL, 0);
      apb(1, `OFS_CC_CONTROL, {24'h0, cc});
      apb(1, `OFS_PRESCALER_EDGE, {24'h0, pr});
      apb(1, `OFS_TIMER_MODE_CONTROL, {24'h0, md});
   endtask
   task automatic rd2();
      apb(0, `OFS_CAPTURE_COMPARE_A, 0);
      va = rd[15:0];
      apb(0, `OFS_CAPTURE_COMPARE_B, 0);
      vb = rd[15:0];
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      hi_n += timer_out_pin;
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         ev = exp_q.pop_front();
         mv = msk_q.pop_front();
         if (mv != 0) chk(prdata & mv, ev);
      end
      if (cyc == 90000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {n_mismatch, n_checks, cyc, hi_n} = '0;
      void'($urandom(91729));
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      apb(1, 12'h024, 32'hFFFFFFFF);
      for (int a = 0; a <= 'h24; a += 4) apb(0, a[11:0], 0, a == 'h20 ? 7 : 0, '1);
      va = 16'($urandom_range(16, 60));
      vb = va + 16'($urandom_range(8, 40));
      df = vb - va;
      apb(1, `OFS_CAPTURE_COMPARE_A, {16'hFFFF, va});
      apb(1, `OFS_CAPTURE_COMPARE_B, {16'hFFFF, vb});
      apb(0, `OFS_CAPTURE_COMPARE_A, 0, {16'h0, va}, '1);
      apb(0, `OFS_CAPTURE_COMPARE_B, 0, {16'h0, vb}, '1);
      apb(1, `OFS_TIMER_OUT_CONTROL, 32'h33);
      cfg(8'h04, 8'h00, 8'h00);
      hi_n = 0;
      apb(1, `OFS_TIMER_OUT_CONTROL, 32'h73);
      apb(0, `OFS_TIMER_OUT_CONTROL, 0, 0, 32'h40);
      repeat (200) @(posedge sys_clk);
      chk(hi_n, df);
      apb(0, `OFS_IRQ_STATUS, 0, 3, 3);
      apb(0, `OFS_TIMER_COUNT, 0);
      chk(irq, 0);
      apb(1, `OFS_IRQ_MASK, 0);
      chk(irq, 1);
      apb(1, `OFS_IRQ_STATUS, 7);
      chk(irq, 0);
      apb(1, `OFS_TIMER_MODE_CONTROL, 0);
      apb(0, `OFS_TIMER_COUNT, 0, 0, 32'hFFFF);
      cfg(8'h04, 8'h05, 8'h70);
      pulse_source_inst.pulse(6, 5, 10);
      rd2();
      df = vb - va;
      chk(df, 6);
      for (int e = 0; e < 2; e++) begin
         cfg(8'h04, 8'h07, 8'(e << 4));
         pulse_source_inst.pulse(9, 0, 10);
         rd2();
         df = e ? va - vb : vb - va;
         chk(df, 9);
      end
      cfg(8'h08, 8'h07, 8'h10);
      pulse_source_inst.pulse(7, 0, 13);
      pulse_source_inst.pulse(7, 0, 30);
      rd2();
      df = vb - va;
      chk(df, 14);
      cfg(8'h04, 8'h00, 8'h00);
      apb(1, `OFS_IRQ_MASK, 2);
      apb(1, `OFS_TIMER_OUT_CONTROL, 32'h23);
      repeat (120) @(posedge sys_clk);
      apb(1, `OFS_CAPTURE_COMPARE_B, 32'h0400);
      @(posedge sys_clk);
      apb(1, `OFS_TIMER_OUT_CONTROL, 32'h33);
      apb(1, `OFS_IRQ_STATUS, 2);
      apb(1, `OFS_IRQ_MASK, 0);
      apb(0, `OFS_IRQ_STATUS, 0, 0, 2);
      repeat (1000) @(posedge sys_clk);
      apb(0, `OFS_IRQ_STATUS, 0, 2, 2);
      repeat (65600) @(posedge sys_clk);
      apb(0, `OFS_TIMER_MODE_CONTROL, 0, 5, 32'hF);
      apb(0, `OFS_TIMER_MODE_CONTROL, 0, 5, 32'hF);
      apb(0, `OFS_IRQ_STATUS, 0, 4, 4);
      chk(irq, 1);
      apb(1, `OFS_TIMER_MODE_CONTROL, 32'h04);
      apb(0, `OFS_TIMER_MODE_CONTROL, 0, 4, 32'hF);
      end_of_test();
   end
endmodule // tb_timer_pulse_measure_oneshot
`default_nettype wire
